// *** src/dlm_pkg.sv ***
// Package: register map, field layout and carriers of the data-line monitor bank
`default_nettype none
package dlm_pkg;

    // ******************************************
    // Register map (byte offsets)
    // ******************************************
    localparam logic [7:0] DLM_OFS_POS_RESULT_HI = 8'h43;
    localparam logic [7:0] DLM_OFS_POS_RESULT_LO = 8'h44;
    localparam logic [7:0] DLM_OFS_NEG_RESULT_HI = 8'h45;
    localparam logic [7:0] DLM_OFS_NEG_RESULT_LO = 8'h46;
    localparam logic [7:0] DLM_OFS_DRIVER_SELECT = 8'h47;
    localparam logic [7:0] DLM_OFS_DEVICE_IDENT  = 8'h48;

    // ******************************************
    // Field layout and reset values
    // ******************************************
    localparam int         DLM_POS_LEVEL_LSB  = 5;
    localparam int         DLM_NEG_LEVEL_LSB  = 2;
    localparam int         DLM_LEVEL_W        = 3;
    localparam int         DLM_SPARE_LSB      = 0;
    localparam int         DLM_SPARE_W        = 2;
    localparam int         DLM_PART_LSB       = 3;
    localparam int         DLM_REV_LSB        = 0;
    localparam int         DLM_ID_FIELD_W     = 3;
    localparam int         DLM_RESULT_W       = 16;
    localparam logic [7:0]  DLM_DRIVER_RESET  = 8'h00;
    localparam logic [15:0] DLM_RESULT_RESET  = 16'h0000;
    localparam logic [15:0] DLM_RESULT_MAX_MV = 16'h0e10;
    localparam logic [7:0]  DLM_READ_ZERO     = 8'h00;

    // ******************************************
    // Driver level codes
    // ******************************************
    typedef enum logic [2:0] {
        DLM_LVL_HIGH_IMPEDANCE = 3'h0,
        DLM_LVL_0V0            = 3'h1,
        DLM_LVL_0V6            = 3'h2,
        DLM_LVL_1V2            = 3'h3,
        DLM_LVL_2V0            = 3'h4,
        DLM_LVL_2V7            = 3'h5,
        DLM_LVL_3V3            = 3'h6,
        DLM_LVL_SHORT          = 3'h7
    } dlm_level_t;

    // ******************************************
    // Carriers
    // ******************************************
    typedef struct packed {
        logic        valid;
        logic [15:0] value;
    } dlm_result_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dlm_req_t;

endpackage : dlm_pkg
`default_nettype wire

// *** src/dlm_regs.sv ***
// Data-line monitor register bank: two result registers, driver select, identification
`default_nettype none
// Functional notes
// (RULE_01) The positive-line result is a read-only 16-bit millivolt value, 1 mV per count, 0 to 3600, zero at reset; stored unclamped above 3600.
// (RULE_02) The negative-line result is a read-only 16-bit millivolt value, 1 mV per count, 0 to 3600, zero at reset; stored unclamped above 3600.
// (RULE_03) Bits 7 to 5 of the driver select are the read/write positive-line level, zero at reset, code 7 shorts both lines.
// (RULE_04) Bits 4 to 2 of the driver select are the read/write negative-line level, zero at reset, code 7 reserved.
// (RULE_05) The identification byte is read-only: part code in bits 5 to 3, revision in 2 to 0, bits 7 to 6 read zero.
// (RULE_06) A two-byte result read returns both bytes from one conversion via a snapshot taken at the high byte.
module dlm_regs #(
    // Arbitrary identification values
    parameter logic [2:0] PART_CODE     = 3'h5,
    parameter logic [2:0] REVISION_CODE = 3'h2
) (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rstn,
    // Register access port
    input  wire dlm_pkg::dlm_req_t    i_req,
    output var  logic [7:0]           o_rdata,
    output var  logic                 o_rvalid,
    // Conversion results from the converter
    input  wire dlm_pkg::dlm_result_t i_pos_result,
    input  wire dlm_pkg::dlm_result_t i_neg_result,
    // Driver controls
    output var  logic [2:0]           o_pos_line_drive_level,
    output var  logic [2:0]           o_neg_line_drive_level,
    output var  logic                 o_lines_shorted
);

    // ******************************************
    // Elaboration checks
    // ******************************************
    // Two spare bits sit above the part code in the identification byte
    if (dlm_pkg::DLM_PART_LSB + dlm_pkg::DLM_ID_FIELD_W > 8 - dlm_pkg::DLM_SPARE_W ||
        dlm_pkg::DLM_REV_LSB + dlm_pkg::DLM_ID_FIELD_W > dlm_pkg::DLM_PART_LSB)
    begin : g_bad_layout
        $error("dlm_regs: identification fields overlap");
    end

    if (dlm_pkg::DLM_NEG_LEVEL_LSB + dlm_pkg::DLM_LEVEL_W > dlm_pkg::DLM_POS_LEVEL_LSB ||
        dlm_pkg::DLM_POS_LEVEL_LSB + dlm_pkg::DLM_LEVEL_W > 8)
    begin : g_bad_levels
        $error("dlm_regs: driver level fields overlap or leave the byte");
    end

    // Result ports and the two-byte read path are sized for 16 bits
    if (dlm_pkg::DLM_RESULT_W != 16)
    begin : g_bad_result_width
        $error("dlm_regs: result width must be two bytes");
    end

    // ******************************************
    // State
    // ******************************************
    logic [15:0] pos_value_q;
    logic [15:0] neg_value_q;
    logic [7:0]  driver_q;
    logic [7:0]  pos_snap_lo_q;
    logic [7:0]  neg_snap_lo_q;
    logic        pos_snap_ok_q;
    logic        neg_snap_ok_q;
    logic [7:0]  rdata_q;
    logic        rvalid_q;

    // ******************************************
    // Helpers
    // ******************************************
    // Byte-address match, shared by every register decode
    function automatic logic f_hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction

    // Low byte of a result: the snapshot while one is pending, else the live value
    function automatic logic [7:0] f_low_byte(input logic snap_ok, input logic [7:0] snap,
                                              input logic [15:0] live);
        return snap_ok ? snap : live[7:0];
    endfunction

    // ******************************************
    // Decode
    // ******************************************
    wire logic hit_pos_hi = f_hit(i_req.addr, dlm_pkg::DLM_OFS_POS_RESULT_HI);
    wire logic hit_pos_lo = f_hit(i_req.addr, dlm_pkg::DLM_OFS_POS_RESULT_LO);
    wire logic hit_neg_hi = f_hit(i_req.addr, dlm_pkg::DLM_OFS_NEG_RESULT_HI);
    wire logic hit_neg_lo = f_hit(i_req.addr, dlm_pkg::DLM_OFS_NEG_RESULT_LO);
    wire logic hit_drv    = f_hit(i_req.addr, dlm_pkg::DLM_OFS_DRIVER_SELECT);
    wire logic hit_id     = f_hit(i_req.addr, dlm_pkg::DLM_OFS_DEVICE_IDENT);

    wire logic rd_pos_hi = i_req.rd && hit_pos_hi;
    wire logic rd_pos_lo = i_req.rd && hit_pos_lo;
    wire logic rd_neg_hi = i_req.rd && hit_neg_hi;
    wire logic rd_neg_lo = i_req.rd && hit_neg_lo;
    // Results are read-only, so writes elsewhere than the driver byte are dropped
    wire logic wr_drv    = i_req.wr && hit_drv;

    wire logic [7:0] ident_byte =
        {dlm_pkg::DLM_READ_ZERO[dlm_pkg::DLM_SPARE_W-1:0], PART_CODE, REVISION_CODE}; // RULE_05

    // Low byte: snapshot if the high byte was read and its low byte not yet, else live value
    wire logic [7:0] pos_lo_byte = f_low_byte(pos_snap_ok_q, pos_snap_lo_q, pos_value_q); // RULE_06
    wire logic [7:0] neg_lo_byte = f_low_byte(neg_snap_ok_q, neg_snap_lo_q, neg_value_q); // RULE_06

    // Unmapped offsets read as zero
    wire logic [7:0] rd_mux =
        hit_pos_hi ? pos_value_q[15:8] :                 // RULE_01
        hit_pos_lo ? pos_lo_byte :                       // RULE_01
        hit_neg_hi ? neg_value_q[15:8] :                 // RULE_02
        hit_neg_lo ? neg_lo_byte :                       // RULE_02
        hit_drv    ? driver_q :
        hit_id     ? ident_byte :
                     dlm_pkg::DLM_READ_ZERO;

    // ******************************************
    // Result registers
    // ******************************************
    // Stored as delivered; values above full scale are not clamped
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pos_value_q <= dlm_pkg::DLM_RESULT_RESET; // RULE_01
            neg_value_q <= dlm_pkg::DLM_RESULT_RESET; // RULE_02
        end
        else
        begin
            if (i_pos_result.valid)
                pos_value_q <= i_pos_result.value; // RULE_01
            if (i_neg_result.valid)
                neg_value_q <= i_neg_result.value; // RULE_02
        end
    end

    // ******************************************
    // Snapshots of the low bytes
    // ******************************************
    // Taken at the high-byte read so a new conversion between bytes cannot tear the value
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pos_snap_lo_q <= dlm_pkg::DLM_READ_ZERO;
            neg_snap_lo_q <= dlm_pkg::DLM_READ_ZERO;
            pos_snap_ok_q <= 1'b0;
            neg_snap_ok_q <= 1'b0;
        end
        else
        begin
            if (rd_pos_hi)
            begin
                pos_snap_lo_q <= pos_value_q[7:0]; // RULE_06
                pos_snap_ok_q <= 1'b1;
            end
            else if (rd_pos_lo)
                pos_snap_ok_q <= 1'b0;
            if (rd_neg_hi)
            begin
                neg_snap_lo_q <= neg_value_q[7:0]; // RULE_06
                neg_snap_ok_q <= 1'b1;
            end
            else if (rd_neg_lo)
                neg_snap_ok_q <= 1'b0;
        end
    end

    // ******************************************
    // Driver select and read port
    // ******************************************
    // Reserved code 7 on the negative line is stored as written
    // Read data moves only on a read, so it holds until the next one
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            driver_q <= dlm_pkg::DLM_DRIVER_RESET; // RULE_03 RULE_04
            rdata_q  <= dlm_pkg::DLM_READ_ZERO;
            rvalid_q <= 1'b0;
        end
        else
        begin
            if (wr_drv)
                driver_q <= i_req.wdata; // RULE_03 RULE_04
            rvalid_q <= i_req.rd;
            if (i_req.rd)
                rdata_q <= rd_mux;
        end
    end

    // ******************************************
    // Outputs
    // ******************************************
    logic [2:0] pos_lvl_q;
    logic [2:0] neg_lvl_q;
    logic       short_q;

    wire logic [2:0] pos_lvl_d = driver_q[dlm_pkg::DLM_POS_LEVEL_LSB +: dlm_pkg::DLM_LEVEL_W];
    wire logic [2:0] neg_lvl_d = driver_q[dlm_pkg::DLM_NEG_LEVEL_LSB +: dlm_pkg::DLM_LEVEL_W];

    // One cycle behind driver_q so every output is a flop
    // Short follows the positive code alone; negative code 7 drives nothing
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pos_lvl_q <= dlm_pkg::DLM_LVL_HIGH_IMPEDANCE;
            neg_lvl_q <= dlm_pkg::DLM_LVL_HIGH_IMPEDANCE;
            short_q   <= 1'b0;
        end
        else
        begin
            pos_lvl_q <= pos_lvl_d; // RULE_03
            neg_lvl_q <= neg_lvl_d; // RULE_04
            short_q   <= pos_lvl_d == dlm_pkg::DLM_LVL_SHORT; // RULE_03
        end
    end

    assign o_rdata                = rdata_q;
    assign o_rvalid               = rvalid_q;
    assign o_pos_line_drive_level = pos_lvl_q;
    assign o_neg_line_drive_level = neg_lvl_q;
    assign o_lines_shorted        = short_q;

endmodule // dlm_regs
`default_nettype wire

// *** tb/dlm_asserts.sv ***
// Checker for the data-line monitor register bank ports
`default_nettype none
module dlm_asserts (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rstn,
    // Register port
    input  wire dlm_pkg::dlm_req_t    i_req,
    input  wire logic [7:0]           o_rdata,
    input  wire logic                 o_rvalid,
    // Results and driver controls
    input  wire dlm_pkg::dlm_result_t i_pos_result,
    input  wire dlm_pkg::dlm_result_t i_neg_result,
    input  wire logic [2:0]           o_pos_line_drive_level,
    input  wire logic [2:0]           o_neg_line_drive_level,
    input  wire logic                 o_lines_shorted
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Shadow copies of the stored results
    // ****************************************
    logic [15:0] pos_q;
    logic [15:0] neg_q;
    wire         drv_wr = i_req.wr && i_req.addr == 8'h47;
    always_ff @(posedge i_clk or negedge i_rstn)
        if (!i_rstn) pos_q <= 16'h0000;
        else if (i_pos_result.valid) pos_q <= i_pos_result.value;
    always_ff @(posedge i_clk or negedge i_rstn)
        if (!i_rstn) neg_q <= 16'h0000;
        else if (i_neg_result.valid) neg_q <= i_neg_result.value;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_drv_wr;
        drv_wr;
    endsequence
    property p_rvalid; o_rvalid == $past(i_req.rd); endproperty
    a_rvalid: assert property (p_rvalid) else $error("read answer timing");
    property p_ident; i_req.rd && i_req.addr == 8'h48 |=> o_rdata[7:6] == 2'h0; endproperty
    a_ident: assert property (p_ident) else $error("ident spare bits");
    property p_pos_hi; i_req.rd && i_req.addr == 8'h43 |=> o_rdata == $past(pos_q[15:8]); endproperty
    a_pos_hi: assert property (p_pos_hi) else $error("pos result high byte");
    property p_neg_hi; i_req.rd && i_req.addr == 8'h45 |=> o_rdata == $past(neg_q[15:8]); endproperty
    a_neg_hi: assert property (p_neg_hi) else $error("neg result high byte");
    property p_pos_drv; s_drv_wr |=> ##1 o_pos_line_drive_level == $past(i_req.wdata[7:5], 2); endproperty
    a_pos_drv: assert property (p_pos_drv) else $error("pos level update");
    property p_neg_drv; s_drv_wr |=> ##1 o_neg_line_drive_level == $past(i_req.wdata[4:2], 2); endproperty
    a_neg_drv: assert property (p_neg_drv) else $error("neg level update");
    property p_short; o_lines_shorted == (o_pos_line_drive_level == 3'h7); endproperty
    a_short: assert property (p_short) else $error("short flag");
    property p_hold; !drv_wr |=> ##1 $stable({o_pos_line_drive_level, o_neg_line_drive_level}); endproperty
    a_hold: assert property (p_hold) else $error("levels moved without write");
endmodule // dlm_asserts
`default_nettype wire

// *** tb/dlm_host_model.sv ***
// Host model issuing byte transfers on the register port
`default_nettype none
module dlm_host_model (
    // Clock
    input  wire logic              i_clk,
    // Register port
    output var  dlm_pkg::dlm_req_t o_req,
    input  wire logic [7:0]        i_rdata,
    input  wire logic              i_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_req = '0;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
        @(negedge i_clk);
        o_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge i_clk);
        // Idle lines toggle so stale values cannot pass
        o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        ok = i_rvalid | w;
        q = i_rdata;
    endtask
endmodule // dlm_host_model
`default_nettype wire

// *** tb/tb.sv ***
// Testbench for the data-line monitor register bank
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0;
    logic i_rstn = 0;
    dlm_pkg::dlm_req_t    req;
    dlm_pkg::dlm_result_t pos_r = '0;
    dlm_pkg::dlm_result_t neg_r = '0;
    logic [7:0] rdata, q, d;
    logic [2:0] pos_lv, neg_lv;
    logic       rvalid, shorted, ok;
    logic [15:0] v, w;
    int failures = 0;
    int n_tests = 0;
    always #2 i_clk = ~i_clk;
    // Arbitrary identification values
    localparam logic [2:0] TB_PART_CODE = 3'h3;
    localparam logic [2:0] TB_REV_CODE  = 3'h6;
    dlm_regs #(.PART_CODE(TB_PART_CODE), .REVISION_CODE(TB_REV_CODE)) dut (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_req(req), .o_rdata(rdata), .o_rvalid(rvalid), .i_pos_result(pos_r), .i_neg_result(neg_r),
        .o_pos_line_drive_level(pos_lv), .o_neg_line_drive_level(neg_lv), .o_lines_shorted(shorted));
    dlm_host_model u_host (.i_clk(i_clk), .o_req(req), .i_rdata(rdata), .i_rvalid(rvalid));
    // ****************************************
    // Tasks
    // ****************************************
    function automatic logic [15:0] f_exp_levels(input logic [7:0] ctl);
        return {9'h000, ctl[7:5], ctl[4:2], ctl[7:5] == 3'h7};
    endfunction
    function automatic logic [7:0] f_exp_ident(input logic [2:0] part, input logic [2:0] rev);
        return {2'b00, part, rev};
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        u_host.xfer(1'b0, a, 8'h00, q, ok);
        chk(nm, {8'h01, e}, {7'h00, ok, q});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] dd);
        u_host.xfer(1'b1, a, dd, q, ok);
    endtask
    task automatic ld(input logic neg, input logic [15:0] val);
        @(negedge i_clk);
        if (neg) neg_r = '{1'b1, val};
        else pos_r = '{1'b1, val};
        @(negedge i_clk);
        pos_r = '{1'b0, ~pos_r.value};
        neg_r = '{1'b0, ~neg_r.value};
    endtask
    task automatic stop_test;
        if (failures == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        void'($urandom(32'hef2d));
        repeat (8) @(posedge i_clk);
        @(negedge i_clk) i_rstn = 1'b1;
        rd(8'h43, 8'h00, "pos_rst");
        rd(8'h46, 8'h00, "neg_rst");
        rd(8'h47, 8'h00, "drv_rst");
        wr(8'h48, 8'hff);
        rd(8'h48, f_exp_ident(TB_PART_CODE, TB_REV_CODE), "ident");
        for (int i = 0; i < 8; i++)
        begin
            d = {i[2:0], 3'(7 - i), 2'($urandom)};
            wr(8'h47, d);
            rd(8'h47, d, "drv_rb");
            chk("levels", f_exp_levels(d), {9'h0, pos_lv, neg_lv, shorted});
        end
        for (int k = 0; k < 6; k++)
        begin
            v = (k < 2) ? 16'h0e10 : 16'($urandom_range(3600));
            w = 16'($urandom_range(3600));
            ld(k[0], v);
            wr(k[0] ? 8'h45 : 8'h43, 8'hff);
            rd(k[0] ? 8'h45 : 8'h43, v[15:8], "res_hi");
            ld(k[0], w);
            rd(k[0] ? 8'h46 : 8'h44, v[7:0], "res_snap");
            rd(k[0] ? 8'h46 : 8'h44, w[7:0], "res_live");
        end
        // Reset in mid-run: a shorted driver code and a pending snapshot must clear
        wr(8'h47, 8'hed);
        ld(1'b0, 16'h0e10);
        rd(8'h43, 8'h0e, "pre_rst_hi");
        chk("pre_rst_levels", f_exp_levels(8'hed), {9'h0, pos_lv, neg_lv, shorted});
        @(negedge i_clk) i_rstn = 1'b0;
        repeat (2) @(negedge i_clk);
        i_rstn = 1'b1;
        chk("rst_levels", f_exp_levels(8'h00), {9'h0, pos_lv, neg_lv, shorted});
        rd(8'h44, 8'h00, "rst_snap");
        rd(8'h43, 8'h00, "rst_pos");
        rd(8'h45, 8'h00, "rst_neg");
        rd(8'h47, 8'h00, "rst_drv");
        rd(8'h50, 8'h00, "unmapped");
        stop_test;
    end
endmodule // tb
bind dlm_regs dlm_asserts u_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .i_pos_result(i_pos_result), .i_neg_result(i_neg_result),
    .o_pos_line_drive_level(o_pos_line_drive_level), .o_neg_line_drive_level(o_neg_line_drive_level),
    .o_lines_shorted(o_lines_shorted));
`default_nettype wire
